// File: core/rtcps_pkg.sv
// constants, types and helpers for the rtc control and prescaler block
// assumes one core clock; oscillator and pin levels arrive synchronous
// Function
// - control bit 7 selects test mode
// - stop bit clears divider above the two low stages, which keep running
// - soft reset bit reads as zero
// - enable bit passes correction interrupt pulses
// - control bit 1 selects 12/24 hours
// - control bit 0 selects load capacitance
// - test mode turns clock pin input
// - test clock divided by 64 to 1 Hz
// - stop clears test prescaler, holds it
// - first tick edge 32, then every 64
// - test entry leaves prescaler state undefined
// - stop clears upper stages, no ticks
// - stop gates clock outputs below 8 kHz
// - stopped counters load, do not advance
// - stage zero at 32 kHz, top rise ticks
// - two low stages survive stop
// - soft reset loads all reset values
package rtcps_pkg;
   // register word indexes; byte address is four times the index
   localparam logic [7:0] RTCPS_IDX_CTRL = 8'h00;
   localparam logic [7:0] RTCPS_IDX_RELOAD = 8'h10;
   localparam logic [7:0] RTCPS_IDX_CFG = 8'h11;
   localparam logic [7:0] RTCPS_IDX_CLKSEL = 8'h12;
   localparam logic [7:0] RTCPS_IDX_SECONDS = 8'h13;
   localparam logic [7:0] RTCPS_IDX_PRESC = 8'h14;
   localparam logic [7:0] RTCPS_IDX_NONE = 8'hFF;
   // primary control fields
   localparam int RTCPS_BIT_TEST = 7;
   localparam int RTCPS_BIT_STOP = 5;
   localparam int RTCPS_BIT_SR = 4;
   localparam int RTCPS_BIT_CIE = 2;
   localparam int RTCPS_BIT_1224 = 1;
   localparam int RTCPS_BIT_CAP = 0;
   localparam logic [7:0] RTCPS_CTRL_MASK = 8'hA7;
   localparam logic [7:0] RTCPS_CFG_MASK = 8'h1F;
   localparam logic [7:0] RTCPS_SOFT_RESET_CMD = 8'h58;
   localparam logic [7:0] RTCPS_REG_RESET = 8'h00;
   // prescaler shape
   localparam int RTCPS_PRESC_W = 15;
   localparam int RTCPS_TEST_W = 6;
   localparam logic [14:0] RTCPS_STOP_KEEP = 15'h0003;
   localparam logic [14:0] RTCPS_PRESC_ONE = 15'h0001;
   localparam logic [5:0] RTCPS_TEST_ONE = 6'h01;
   localparam logic [31:0] RTCPS_SEC_ONE = 32'h0000_0001;
   // clock output selections
   localparam logic [2:0] RTCPS_CLKSEL_RESET = 3'h0;
   localparam logic [2:0] RTCPS_CLKSEL_GATED = 3'h3;
   localparam logic [2:0] RTCPS_CLKSEL_1HZ = 3'h6;
   // ahb-lite encodings
   localparam int RTCPS_HTRANS_ACTIVE = 1;
   localparam int RTCPS_IDX_LSB = 2;
   localparam int RTCPS_IDX_MSB = 9;

   // pending data phase of an accepted transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] idx;
   } rtcps_dphase_type;

   // byte address to word index, out-of-range maps to none
   function automatic logic [7:0] rtcps_widx(input logic [31:0] a);
      rtcps_widx = (a[31:RTCPS_IDX_MSB+1] == '0) ?
         a[RTCPS_IDX_MSB:RTCPS_IDX_LSB] : RTCPS_IDX_NONE;
   endfunction

   // rising edge between two samples
   function automatic logic rtcps_rise(input logic prev, input logic cur);
      rtcps_rise = cur & ~prev;
   endfunction
endpackage

// File: core/rtcps_core.sv
// rtc primary control register, prescaler, test clock and ahb-lite slave
// assumes a single ahb-lite master whose hready is this hreadyout
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module rtcps_core (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // oscillator and clock pin
   input wire logic osc_in,
   input wire logic clock_output_pin_i,
   output logic clock_output_pin_o,
   output logic clock_output_pin_oe,
   // correction events
   input wire logic correction_cycle_pulse,
   output logic correction_irq_pulse,
   // configuration and time outputs
   output logic hour_mode_12,
   output logic load_capacitance_choice,
   output logic [1:0] countdown_source_freq,
   output logic countdown_run_enable,
   output logic countdown_irq_enable,
   output logic countdown_irq_pulse_sel,
   output logic second_tick,
   output logic [31:0] seconds_count
);
   import rtcps_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // bus state
   rtcps_dphase_type dph_ff, nxt_dph;
   logic rd_wait_ff, nxt_rd_wait;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic accept, wr_now, soft_rst;
   logic [7:0] wbyte;

   // register state
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [7:0] reload_ff, nxt_reload;
   logic [7:0] cfg_ff, nxt_cfg;
   logic [2:0] clksel_ff, nxt_clksel;
   logic [31:0] sec_ff, nxt_sec;

   // prescaler state
   logic [14:0] presc_ff, nxt_presc;
   logic [5:0] tdiv_ff, nxt_tdiv;
   logic osc_prev_ff, nxt_osc_prev;
   logic pin_prev_ff, nxt_pin_prev;
   logic tick_ff, nxt_tick;
   logic clock_output_pin_ff, nxt_clock_output_pin;
   logic corr_ff, nxt_corr;
   logic test_mode, stop_on, tick_now, src_edge, freq_bit;

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite decode; reads take one wait state so a write just
   // ahead of them is always seen
   assign accept = hsel & htrans[RTCPS_HTRANS_ACTIVE] & hready;
   assign wr_now = dph_ff.valid & dph_ff.write;
   assign wbyte = hwdata[7:0];
   assign soft_rst = wr_now & (dph_ff.idx == RTCPS_IDX_CTRL) &
      (wbyte == RTCPS_SOFT_RESET_CMD);
   assign hreadyout = ~(dph_ff.valid & ~dph_ff.write & ~rd_wait_ff);
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   // read mux; unmapped words read zero
   always_comb begin
      nxt_dph = dph_ff;
      nxt_rd_wait = 1'b0;
      nxt_hrdata = hrdata_ff;
      if (dph_ff.valid & ~dph_ff.write & ~rd_wait_ff) begin
         nxt_rd_wait = 1'b1;
         case (dph_ff.idx)
            RTCPS_IDX_CTRL: nxt_hrdata = {24'h0000_00, ctrl_ff};
            RTCPS_IDX_RELOAD: nxt_hrdata = {24'h0000_00, reload_ff};
            RTCPS_IDX_CFG: nxt_hrdata = {24'h0000_00, cfg_ff};
            RTCPS_IDX_CLKSEL: nxt_hrdata = {29'h0000_0000, clksel_ff};
            RTCPS_IDX_SECONDS: nxt_hrdata = sec_ff;
            RTCPS_IDX_PRESC: nxt_hrdata = {11'h000, tdiv_ff, presc_ff};
            default: nxt_hrdata = 32'h0000_0000;
         endcase
      end
      if (hready) begin
         nxt_dph.valid = accept;
         nxt_dph.write = hwrite;
         nxt_dph.idx = rtcps_widx(haddr);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dph_ff <= '0;
         rd_wait_ff <= 1'b0;
         hrdata_ff <= 32'h0000_0000;
      end else if (clk_en) begin
         dph_ff <= nxt_dph;
         rd_wait_ff <= nxt_rd_wait;
         hrdata_ff <= nxt_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers; the soft reset command stores nothing and returns
   // every register to its reset value
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_reload = reload_ff;
      nxt_cfg = cfg_ff;
      nxt_clksel = clksel_ff;
      nxt_sec = sec_ff;
      if (tick_now) begin
         nxt_sec = sec_ff + RTCPS_SEC_ONE;
      end
      if (wr_now) begin
         case (dph_ff.idx)
            RTCPS_IDX_CTRL: nxt_ctrl = wbyte & RTCPS_CTRL_MASK;
            RTCPS_IDX_RELOAD: nxt_reload = wbyte;
            RTCPS_IDX_CFG: nxt_cfg = wbyte & RTCPS_CFG_MASK;
            RTCPS_IDX_CLKSEL: nxt_clksel = wbyte[2:0];
            RTCPS_IDX_SECONDS: nxt_sec = hwdata;
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
      if (soft_rst) begin
         nxt_ctrl = RTCPS_REG_RESET;
         nxt_reload = RTCPS_REG_RESET;
         nxt_cfg = RTCPS_REG_RESET;
         nxt_clksel = RTCPS_CLKSEL_RESET;
         nxt_sec = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_ff <= RTCPS_REG_RESET;
         reload_ff <= RTCPS_REG_RESET;
         cfg_ff <= RTCPS_REG_RESET;
         clksel_ff <= RTCPS_CLKSEL_RESET;
         sec_ff <= 32'h0000_0000;
      end else if (clk_en) begin
         ctrl_ff <= nxt_ctrl;
         reload_ff <= nxt_reload;
         cfg_ff <= nxt_cfg;
         clksel_ff <= nxt_clksel;
         sec_ff <= nxt_sec;
      end
   end

   // configuration fields straight from flops
   assign test_mode = ctrl_ff[RTCPS_BIT_TEST];
   assign stop_on = ctrl_ff[RTCPS_BIT_STOP];
   assign hour_mode_12 = ctrl_ff[RTCPS_BIT_1224];
   assign load_capacitance_choice = ctrl_ff[RTCPS_BIT_CAP];
   assign countdown_source_freq = cfg_ff[4:3];
   assign countdown_run_enable = cfg_ff[2];
   assign countdown_irq_enable = cfg_ff[1];
   assign countdown_irq_pulse_sel = cfg_ff[0];
   assign seconds_count = sec_ff;

   ////////////////////////////////////////////////////////////////////////
   // prescaler: the stop bit lives in this same clock domain, so it
   // hits every stage above the two low ones at one edge and no partial count can appear
   assign src_edge = test_mode ?
      rtcps_rise(pin_prev_ff, clock_output_pin_i) :
      rtcps_rise(osc_prev_ff, osc_in);
   assign tick_now = test_mode ?
      rtcps_rise(tdiv_ff[RTCPS_TEST_W-1], nxt_tdiv[RTCPS_TEST_W-1]) :
      rtcps_rise(presc_ff[RTCPS_PRESC_W-1],
         nxt_presc[RTCPS_PRESC_W-1]);

   always_comb begin
      nxt_osc_prev = osc_in;
      nxt_pin_prev = clock_output_pin_i;
      nxt_presc = presc_ff;
      nxt_tdiv = tdiv_ff;
      // normal chain: low two stages keep running through stop
      if (stop_on) begin
         nxt_presc = presc_ff & RTCPS_STOP_KEEP;
         if (src_edge & ~test_mode) begin
            nxt_presc = (presc_ff + RTCPS_PRESC_ONE) &
               RTCPS_STOP_KEEP;
         end
      end else if (src_edge & ~test_mode) begin
         nxt_presc = presc_ff + RTCPS_PRESC_ONE;
      end
      // test chain is not cleared on entry, only by stop or soft reset
      if (stop_on) begin
         nxt_tdiv = 6'h00;
      end else if (src_edge & test_mode) begin
         nxt_tdiv = tdiv_ff + RTCPS_TEST_ONE;
      end
      if (soft_rst) begin
         nxt_presc = 15'h0000;
         nxt_tdiv = 6'h00;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         presc_ff <= 15'h0000;
         tdiv_ff <= 6'h00;
         osc_prev_ff <= 1'b0;
         pin_prev_ff <= 1'b0;
      end else if (clk_en) begin
         presc_ff <= nxt_presc;
         tdiv_ff <= nxt_tdiv;
         osc_prev_ff <= nxt_osc_prev;
         pin_prev_ff <= nxt_pin_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock output source; slow rates are gated while stopped because
   // their stages are held at zero anyway
   always_comb begin
      case (clksel_ff)
         3'h0: freq_bit = osc_prev_ff;
         3'h1: freq_bit = presc_ff[0];
         3'h2: freq_bit = presc_ff[1];
         3'h3: freq_bit = presc_ff[2];
         3'h4: freq_bit = presc_ff[3];
         3'h5: freq_bit = presc_ff[4];
         RTCPS_CLKSEL_1HZ: freq_bit = presc_ff[RTCPS_PRESC_W-1];
         default: freq_bit = 1'b0;
      endcase
   end

   // output events and pin drive
   always_comb begin
      nxt_clock_output_pin = freq_bit;
      if (stop_on & (clksel_ff >= RTCPS_CLKSEL_GATED)) begin
         nxt_clock_output_pin = 1'b0;
      end
      nxt_tick = tick_now & ~stop_on;
      nxt_corr = correction_cycle_pulse & ctrl_ff[RTCPS_BIT_CIE];
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         clock_output_pin_ff <= 1'b0;
         tick_ff <= 1'b0;
         corr_ff <= 1'b0;
      end else if (clk_en) begin
         clock_output_pin_ff <= nxt_clock_output_pin;
         tick_ff <= nxt_tick;
         corr_ff <= nxt_corr;
      end
   end

   assign clock_output_pin_o = clock_output_pin_ff;
   assign clock_output_pin_oe = ~test_mode;
   assign second_tick = tick_ff;
   assign correction_irq_pulse = corr_ff;
endmodule
`default_nettype wire

// File: test/rtcps_core_asserts.sv
// checker for the rtc control register and prescaler block
// assumes clk_en high during bus traffic, one master on hreadyout
`timescale 1ns/10ps
`default_nettype none
module rtcps_core_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   // pins, events and time
   input wire logic clock_output_pin_oe,
   input wire logic correction_cycle_pulse,
   input wire logic correction_irq_pulse,
   input wire logic hour_mode_12,
   input wire logic load_capacitance_choice,
   input wire logic second_tick,
   input wire logic [31:0] seconds_count
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic acc;
   logic wr_ctrl_ff;
   logic rd_ctrl_ff;
   logic stop_ff;
   ////////////////////////////////////////////////////////////////////////
   // track control register data phases; stop copy changes on the same edge as the real bit
   assign acc = hsel & htrans[1] & hready;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wr_ctrl_ff <= 1'b0;
         rd_ctrl_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         wr_ctrl_ff <= acc & hwrite & (haddr == 32'h0000_0000);
         if (acc) begin
            rd_ctrl_ff <= !hwrite & (haddr == 32'h0000_0000);
         end else if (hreadyout) begin
            rd_ctrl_ff <= 1'b0;
         end
         if (wr_ctrl_ff) begin
            stop_ff <= hwdata[5];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_irq;
      correction_irq_pulse |-> $past(correction_cycle_pulse);
   endproperty
   a_irq: assert property (p_irq) else $error("stray correction irq");
   property p_oe;
      wr_ctrl_ff |=> clock_output_pin_oe == !$past(hwdata[7]);
   endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
   property p_hour;
      wr_ctrl_ff |=> hour_mode_12 == $past(hwdata[1]);
   endproperty
   a_hour: assert property (p_hour) else $error("hour mode wrong");
   property p_cap;
      wr_ctrl_ff |=> load_capacitance_choice == $past(hwdata[0]);
   endproperty
   a_cap: assert property (p_cap) else $error("cap choice wrong");
   property p_soft;
      wr_ctrl_ff && hwdata[7:0] == 8'h58 |=>
         seconds_count == 32'h0000_0000 && clock_output_pin_oe;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset missed");
   property p_sec;
      second_tick |-> seconds_count == $past(seconds_count) + 32'h0000_0001;
   endproperty
   a_sec: assert property (p_sec) else $error("tick not counted");
   property p_stop;
      stop_ff && $past(stop_ff, 3) |-> !second_tick;
   endproperty
   a_stop: assert property (p_stop) else $error("tick while stopped");
   property p_rd0;
      rd_ctrl_ff && hreadyout |-> (hrdata & 32'h0000_0058) == 32'h0000_0000;
   endproperty
   a_rd0: assert property (p_rd0) else $error("ctrl reads set bits");
endmodule
bind rtcps_core rtcps_core_asserts rtcps_core_asserts_i (.core_clk, .rst_n,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata, .hreadyout,
   .clock_output_pin_oe, .correction_cycle_pulse, .correction_irq_pulse,
   .hour_mode_12, .load_capacitance_choice, .second_tick, .seconds_count);
`default_nettype wire

// File: test/test_rtcps_core.sv
// self-checking bench for the rtc control register and prescaler
// assumes the checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module test_rtcps_core;
   logic core_clk, rst_n, clk_en, hsel, hwrite, hreadyout, hresp, osc_in;
   logic clock_output_pin_i, clock_output_pin_o, clock_output_pin_oe;
   logic correction_cycle_pulse, correction_irq_pulse, hour_mode_12;
   logic load_capacitance_choice, countdown_run_enable, second_tick;
   logic countdown_irq_enable, countdown_irq_pulse_sel;
   logic [1:0] htrans, countdown_source_freq;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, seconds_count;
   int fail_count = 0;
   int checked = 0;
   localparam logic [31:0] a_ctrl = 32'h0000_0000;
   localparam logic [31:0] a_cfg = 32'h0000_0044;
   localparam logic [31:0] a_sec = 32'h0000_004C;
   localparam logic [31:0] a_clksel = 32'h0000_0048;
   localparam logic [31:0] a_presc = 32'h0000_0050;
   rtcps_core rtcps_core_i (.core_clk, .rst_n, .clk_en, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
      .hreadyout, .hresp, .osc_in, .clock_output_pin_i, .clock_output_pin_o,
      .clock_output_pin_oe, .correction_cycle_pulse, .correction_irq_pulse,
      .hour_mode_12, .load_capacitance_choice, .countdown_source_freq,
      .countdown_run_enable, .countdown_irq_enable, .countdown_irq_pulse_sel,
      .second_tick, .seconds_count);
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one single transfer; waits are cut only by the watchdog
   task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk(r, e);
   endtask
   // test clock pulses, two core cycles high and two low
   task automatic pulses(input int n);
      repeat (n) begin
         clock_output_pin_i <= 1'b1;
         repeat (2) @(posedge core_clk);
         clock_output_pin_i <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rdc(a_ctrl, 32'h0000_0000);
      wr(32'h0000_03FC, 32'h0000_00FF);
      rdc(32'h0000_03FC, 32'h0000_0000);
      wr(a_cfg, 32'h0000_00FF);
      rdc(a_cfg, 32'h0000_001F);
      chk({countdown_source_freq, countdown_run_enable,
         countdown_irq_enable, countdown_irq_pulse_sel}, 32'h0000_001F);
      chk(hresp, 32'h0000_0000);
      wr(a_ctrl, 32'h0000_00FF);
      @(posedge core_clk);
      chk({clock_output_pin_oe, hour_mode_12, load_capacitance_choice},
         32'h0000_0003);
      rdc(a_ctrl, 32'h0000_00A7);
      wr(a_ctrl, 32'h0000_0000);
      @(posedge core_clk);
      chk({clock_output_pin_oe, hour_mode_12, load_capacitance_choice},
         32'h0000_0004);
      $display("register test done");
   endtask
   task automatic t_irq(input logic [31:0] c, input logic [31:0] e);
      wr(a_ctrl, c);
      correction_cycle_pulse <= 1'b1;
      @(posedge core_clk);
      correction_cycle_pulse <= 1'b0;
      @(posedge core_clk);
      chk(correction_irq_pulse, e);
      $display("correction irq test done");
   endtask
   // stop holds the divider, then 32 edges to the first second, 64 after
   task automatic t_test();
      wr(a_ctrl, 32'h0000_00A0);
      pulses(10);
      wr(a_sec, 32'h0000_0064);
      pulses(40);
      rdc(a_sec, 32'h0000_0064);
      wr(a_ctrl, 32'h0000_0080);
      pulses(31);
      rdc(a_sec, 32'h0000_0064);
      pulses(1);
      rdc(a_sec, 32'h0000_0065);
      pulses(63);
      rdc(a_sec, 32'h0000_0065);
      pulses(1);
      rdc(a_sec, 32'h0000_0066);
      $display("test clock test done");
   endtask
   task automatic t_soft();
      wr(a_ctrl, 32'h0000_0087);
      wr(a_cfg, 32'h0000_0005);
      wr(a_ctrl, 32'h0000_0058);
      rdc(a_ctrl, 32'h0000_0000);
      rdc(a_cfg, 32'h0000_0000);
      rdc(a_sec, 32'h0000_0000);
      chk({hour_mode_12, load_capacitance_choice, countdown_source_freq,
         countdown_run_enable, countdown_irq_enable,
         countdown_irq_pulse_sel}, 32'h0000_0000);
      $display("soft reset test done");
   endtask
   // oscillator pulses, two core cycles high and two low
   task automatic oscp(input int n);
      repeat (n) begin
         osc_in <= 1'b1;
         repeat (2) @(posedge core_clk);
         osc_in <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask
   // normal chain from the oscillator; relies on soft reset having
   // cleared it, and stop must keep only the two low stages counting
   task automatic t_norm();
      oscp(10);
      rdc(a_presc, 32'h0000_000A);
      // frozen enable must swallow oscillator edges
      clk_en <= 1'b0;
      oscp(4);
      clk_en <= 1'b1;
      rdc(a_presc, 32'h0000_000A);
      wr(a_ctrl, 32'h0000_0020);
      oscp(5);
      rdc(a_presc, 32'h0000_0003);
      wr(a_clksel, 32'h0000_0003);
      osc_in <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(clock_output_pin_o, 32'h0000_0000);
      // the fast oscillator rate must still reach the pin while stopped
      wr(a_clksel, 32'h0000_0000);
      repeat (2) @(posedge core_clk);
      chk(clock_output_pin_o, 32'h0000_0001);
      osc_in <= 1'b0;
      wr(a_ctrl, 32'h0000_0000);
      $display("normal chain test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {core_clk, rst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
      {osc_in, clock_output_pin_i, correction_cycle_pulse} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_irq(32'h0000_0004, 32'h0000_0001);
      t_irq(32'h0000_0000, 32'h0000_0000);
      t_test();
      t_soft();
      t_norm();
      end_of_test();
   end
   // whole run needs fewer than a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
